// File: hsc_consts.svh
// Constants for the seven-four shift-register block codec.
// Assumes inclusion by bare name from the package and the codec module.
`ifndef HSC_CONSTS_SVH
`define HSC_CONSTS_SVH

`define HSC_INFO_W 4
`define HSC_CW_W 7
`define HSC_CNT_W 3
`define HSC_SYN_W 3

// Shift stages inside the four-bit register; stage A receives the feedback.
`define HSC_STG_A 3
`define HSC_STG_B 2
`define HSC_STG_C 1
`define HSC_STG_D 0

// Codeword bit n sits at index n-1.
`define HSC_B1 0
`define HSC_B2 1
`define HSC_B3 2
`define HSC_B4 3
`define HSC_B5 4
`define HSC_B6 5
`define HSC_B7 6

`define HSC_CNT_ZERO 3'h0
`define HSC_CNT_ONE 3'h1
`define HSC_CNT_LAST 3'h6

// Syndrome codes ordered as (sum one, sum two, sum three).
`define HSC_SYN_OK 3'h0
`define HSC_SYN_BIT1 3'h2
`define HSC_SYN_BIT2 3'h4
`define HSC_SYN_BIT3 3'h1
`define HSC_SYN_BIT4 3'h3
`define HSC_SYN_BIT5 3'h7
`define HSC_SYN_BIT6 3'h6
`define HSC_SYN_BIT7 3'h5

`define HSC_MASK_NONE 7'h00
`define HSC_MASK_BIT1 7'h01
`define HSC_MASK_BIT2 7'h02
`define HSC_MASK_BIT3 7'h04
`define HSC_MASK_BIT4 7'h08
`define HSC_MASK_BIT5 7'h10
`define HSC_MASK_BIT6 7'h20
`define HSC_MASK_BIT7 7'h40

`endif

// File: hsc_pkg.sv
// Types shared by the seven-four shift-register block codec.
// Assumes the constants header is on the include path.
`include "hsc_consts.svh"

package hsc_pkg;

  typedef logic [`HSC_INFO_W-1:0] hsc_info_t;
  typedef logic [`HSC_CW_W-1:0] hsc_cw_t;
  typedef logic [`HSC_SYN_W-1:0] hsc_syn_t;
  typedef logic [`HSC_CNT_W-1:0] hsc_cnt_t;

  typedef enum logic [1:0]
  {
    ENC_IDLE = 2'b00,
    ENC_SHIFT = 2'b01,
    ENC_EMIT = 2'b10
  } hsc_enc_state_t;

endpackage

// File: hsc_codec.sv
// Seven-four single-error-correcting codec: shift encoder, serial buffer, checker.
// Assumes all inputs are synchronous to the falling edge of ref_clk_i.
`timescale 1ns/10ps
`include "hsc_consts.svh"

// Behaviour
// - Encoder holds four stages A to D, preloaded with any four-bit word.
// - Bit shifted into stage A is A xor B xor D.
// - Seven shifts per word give parity bits b1..b3 then A, B, C, D.
// - All sixteen codewords differ pairwise in at least three positions.
// - Shift/load low loads the word in parallel; high shifts right once per clock.
// - Checker forms three parity sums over fixed groups of received bits.
// - With all sums even the received word passes unchanged.
// - Each sum gives a syndrome flag, one when odd, zero when even.
// - A single bit error is corrected by inverting the flagged bit.
// - Loading and shifting take effect on the falling clock edge.
module hsc_codec
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic enc_valid_i,
  input wire logic [3:0] enc_info_i,
  output logic enc_ready_o,
  output logic shift_load_o,
  output logic ser_valid_o,
  output logic ser_bit_o,
  output logic ser_last_o,
  input wire logic ser_ready_i,
  input wire logic rx_valid_i,
  input wire logic rx_bit_i,
  output logic chk_valid_o,
  output logic [6:0] chk_word_o,
  output logic [3:0] chk_info_o,
  output logic [2:0] chk_syndrome_o,
  output logic chk_corrected_o
);

  // ****************************************
  // Decoding functions
  // ****************************************

  // Parity sums over the received word, packed as sum one, sum two, sum three.
  function automatic hsc_pkg::hsc_syn_t syndrome_of(input hsc_pkg::hsc_cw_t w);
    logic parity_sum_one;
    logic parity_sum_two;
    logic parity_sum_three;
    parity_sum_one = w[`HSC_B2] ^ w[`HSC_B5] ^ w[`HSC_B6] ^ w[`HSC_B7];
    parity_sum_two = w[`HSC_B1] ^ w[`HSC_B4] ^ w[`HSC_B5] ^ w[`HSC_B6];
    parity_sum_three = w[`HSC_B3] ^ w[`HSC_B4] ^ w[`HSC_B5] ^ w[`HSC_B7];
    syndrome_of = {parity_sum_one, parity_sum_two, parity_sum_three};
  endfunction

  // Bit to invert for a given syndrome; a clean syndrome inverts nothing.
  function automatic hsc_pkg::hsc_cw_t fix_mask(input hsc_pkg::hsc_syn_t syn);
    fix_mask = `HSC_MASK_NONE;
    unique case (syn)
      `HSC_SYN_OK: fix_mask = `HSC_MASK_NONE;
      `HSC_SYN_BIT1: fix_mask = `HSC_MASK_BIT1;
      `HSC_SYN_BIT2: fix_mask = `HSC_MASK_BIT2;
      `HSC_SYN_BIT3: fix_mask = `HSC_MASK_BIT3;
      `HSC_SYN_BIT4: fix_mask = `HSC_MASK_BIT4;
      `HSC_SYN_BIT5: fix_mask = `HSC_MASK_BIT5;
      `HSC_SYN_BIT6: fix_mask = `HSC_MASK_BIT6;
      `HSC_SYN_BIT7: fix_mask = `HSC_MASK_BIT7;
    endcase
  endfunction

  // ****************************************
  // Encoder shift register
  // ****************************************

  hsc_pkg::hsc_enc_state_t state_ff;
  hsc_pkg::hsc_enc_state_t nxt_state;
  hsc_pkg::hsc_info_t stage_ff;
  hsc_pkg::hsc_info_t nxt_stage;
  hsc_pkg::hsc_cnt_t enc_cnt_ff;
  hsc_pkg::hsc_cnt_t nxt_enc_cnt;
  hsc_pkg::hsc_cw_t cw_ff;
  hsc_pkg::hsc_cw_t nxt_cw;
  logic enc_ready_ff;
  logic nxt_enc_ready;
  logic shift_load_ff;
  logic nxt_shift_load;
  logic feedback_bit;
  logic push;
  logic push_bit;
  logic push_last;
  logic tail_vld_ff;

  assign feedback_bit = stage_ff[`HSC_STG_A] ^ stage_ff[`HSC_STG_B] ^ stage_ff[`HSC_STG_D];

  // The shifted-out stream arrives b7 first, so it is captured and replayed in order.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_stage = stage_ff;
    nxt_enc_cnt = enc_cnt_ff;
    nxt_cw = cw_ff;
    nxt_enc_ready = enc_ready_ff;
    nxt_shift_load = shift_load_ff;
    push = 1'b0;
    push_bit = cw_ff[enc_cnt_ff];
    push_last = (enc_cnt_ff == `HSC_CNT_LAST);
    unique case (state_ff)
      hsc_pkg::ENC_IDLE:
      begin
        if (enc_valid_i && enc_ready_ff)
        begin
          nxt_stage = enc_info_i;
          nxt_enc_cnt = `HSC_CNT_ZERO;
          nxt_enc_ready = 1'b0;
          nxt_shift_load = 1'b1;
          nxt_state = hsc_pkg::ENC_SHIFT;
        end
      end
      hsc_pkg::ENC_SHIFT:
      begin
        nxt_stage = {feedback_bit, stage_ff[`HSC_STG_A:`HSC_STG_C]};
        nxt_cw[`HSC_CNT_LAST - enc_cnt_ff] = stage_ff[`HSC_STG_D];
        if (enc_cnt_ff == `HSC_CNT_LAST)
        begin
          nxt_enc_cnt = `HSC_CNT_ZERO;
          nxt_shift_load = 1'b0;
          nxt_state = hsc_pkg::ENC_EMIT;
        end
        else
        begin
          nxt_enc_cnt = enc_cnt_ff + `HSC_CNT_ONE;
        end
      end
      hsc_pkg::ENC_EMIT:
      begin
        if (!tail_vld_ff)
        begin
          push = 1'b1;
          if (enc_cnt_ff == `HSC_CNT_LAST)
          begin
            nxt_enc_cnt = `HSC_CNT_ZERO;
            nxt_enc_ready = 1'b1;
            nxt_state = hsc_pkg::ENC_IDLE;
          end
          else
          begin
            nxt_enc_cnt = enc_cnt_ff + `HSC_CNT_ONE;
          end
        end
      end
      default:
      begin
        nxt_enc_ready = 1'b1;
        nxt_shift_load = 1'b0;
        nxt_state = hsc_pkg::ENC_IDLE;
      end
    endcase
  end

  always_ff @(negedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_ff <= hsc_pkg::ENC_IDLE;
      stage_ff <= 4'h0;
      enc_cnt_ff <= `HSC_CNT_ZERO;
      cw_ff <= 7'h00;
      enc_ready_ff <= 1'b1;
      shift_load_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      stage_ff <= nxt_stage;
      enc_cnt_ff <= nxt_enc_cnt;
      cw_ff <= nxt_cw;
      enc_ready_ff <= nxt_enc_ready;
      shift_load_ff <= nxt_shift_load;
    end
  end

  // ****************************************
  // Two-entry serial output buffer
  // ****************************************

  // A skid pair keeps the serial output straight from flops while the receiver stalls.
  logic head_vld_ff;
  logic nxt_head_vld;
  logic [1:0] head_ff;
  logic [1:0] nxt_head;
  logic nxt_tail_vld;
  logic [1:0] tail_ff;
  logic [1:0] nxt_tail;

  always_comb
  begin
    nxt_head_vld = head_vld_ff;
    nxt_head = head_ff;
    nxt_tail_vld = tail_vld_ff;
    nxt_tail = tail_ff;
    if (head_vld_ff && ser_ready_i)
    begin
      nxt_head_vld = tail_vld_ff;
      nxt_head = tail_ff;
      nxt_tail_vld = 1'b0;
    end
    if (push)
    begin
      if (!nxt_head_vld)
      begin
        nxt_head_vld = 1'b1;
        nxt_head = {push_last, push_bit};
      end
      else
      begin
        nxt_tail_vld = 1'b1;
        nxt_tail = {push_last, push_bit};
      end
    end
  end

  always_ff @(negedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      head_vld_ff <= 1'b0;
      head_ff <= 2'h0;
      tail_vld_ff <= 1'b0;
      tail_ff <= 2'h0;
    end
    else
    begin
      head_vld_ff <= nxt_head_vld;
      head_ff <= nxt_head;
      tail_vld_ff <= nxt_tail_vld;
      tail_ff <= nxt_tail;
    end
  end

  // ****************************************
  // Checker and corrector
  // ****************************************

  hsc_pkg::hsc_cnt_t rx_cnt_ff;
  hsc_pkg::hsc_cnt_t nxt_rx_cnt;
  hsc_pkg::hsc_cw_t rx_word_ff;
  hsc_pkg::hsc_cw_t nxt_rx_word;
  hsc_pkg::hsc_cw_t rx_full;
  hsc_pkg::hsc_syn_t rx_syn;
  logic chk_valid_ff;
  logic nxt_chk_valid;
  hsc_pkg::hsc_cw_t chk_word_ff;
  hsc_pkg::hsc_cw_t nxt_chk_word;
  hsc_pkg::hsc_syn_t chk_syn_ff;
  hsc_pkg::hsc_syn_t nxt_chk_syn;
  logic chk_corr_ff;
  logic nxt_chk_corr;

  // Two errors alias onto a wrong single-bit fix; nothing flags them.
  always_comb
  begin
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_word = rx_word_ff;
    nxt_chk_valid = 1'b0;
    nxt_chk_word = chk_word_ff;
    nxt_chk_syn = chk_syn_ff;
    nxt_chk_corr = chk_corr_ff;
    rx_full = rx_word_ff;
    rx_full[rx_cnt_ff] = rx_bit_i;
    rx_syn = syndrome_of(rx_full);
    if (rx_valid_i)
    begin
      nxt_rx_word = rx_full;
      if (rx_cnt_ff == `HSC_CNT_LAST)
      begin
        nxt_rx_cnt = `HSC_CNT_ZERO;
        nxt_chk_valid = 1'b1;
        nxt_chk_word = rx_full ^ fix_mask(rx_syn);
        nxt_chk_syn = rx_syn;
        nxt_chk_corr = (rx_syn != `HSC_SYN_OK);
      end
      else
      begin
        nxt_rx_cnt = rx_cnt_ff + `HSC_CNT_ONE;
      end
    end
  end

  always_ff @(negedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rx_cnt_ff <= `HSC_CNT_ZERO;
      rx_word_ff <= 7'h00;
      chk_valid_ff <= 1'b0;
      chk_word_ff <= 7'h00;
      chk_syn_ff <= `HSC_SYN_OK;
      chk_corr_ff <= 1'b0;
    end
    else
    begin
      rx_cnt_ff <= nxt_rx_cnt;
      rx_word_ff <= nxt_rx_word;
      chk_valid_ff <= nxt_chk_valid;
      chk_word_ff <= nxt_chk_word;
      chk_syn_ff <= nxt_chk_syn;
      chk_corr_ff <= nxt_chk_corr;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  assign enc_ready_o = enc_ready_ff;
  assign shift_load_o = shift_load_ff;
  assign ser_valid_o = head_vld_ff;
  assign ser_bit_o = head_ff[0];
  assign ser_last_o = head_ff[1];
  assign chk_valid_o = chk_valid_ff;
  assign chk_word_o = chk_word_ff;
  assign chk_info_o = {chk_word_ff[`HSC_B4], chk_word_ff[`HSC_B5], chk_word_ff[`HSC_B6], chk_word_ff[`HSC_B7]};
  assign chk_syndrome_o = chk_syn_ff;
  assign chk_corrected_o = chk_corr_ff;

endmodule

// File: hsc_codec_props.sv
// Port checker for the codec, bound onto it below.
// Assumes every port settles between falling edges.
`timescale 1ns/10ps
module hsc_codec_props
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic enc_valid_i,
  input wire logic [3:0] enc_info_i,
  input wire logic enc_ready_o,
  input wire logic shift_load_o,
  input wire logic ser_valid_o,
  input wire logic ser_bit_o,
  input wire logic ser_last_o,
  input wire logic ser_ready_i,
  input wire logic rx_valid_i,
  input wire logic rx_bit_i,
  input wire logic chk_valid_o,
  input wire logic [6:0] chk_word_o,
  input wire logic [3:0] chk_info_o,
  input wire logic [2:0] chk_syndrome_o,
  input wire logic chk_corrected_o
);
  // ****
  // Properties
  // ****
  // Sampling on the falling edge sees what the codec flops see.
  default clocking @(negedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_take; enc_valid_i && enc_ready_o; endsequence
  sequence s_run; shift_load_o [*7] ##1 !shift_load_o; endsequence
  property p_take; s_take |=> !enc_ready_o && shift_load_o; endproperty
  a_take: assert property (p_take) else $error("word not taken");
  property p_run; $rose(shift_load_o) |-> s_run; endproperty
  a_run: assert property (p_run) else $error("shift run not seven");
  property p_first; (s_take ##0 !ser_valid_o) |-> ##9 ser_valid_o; endproperty
  a_first: assert property (p_first) else $error("first bit late");
  property p_hold; ser_valid_o && !ser_ready_i |=> ser_valid_o && $stable(ser_bit_o) && $stable(ser_last_o); endproperty
  a_hold: assert property (p_hold) else $error("bit dropped in stall");
  property p_pulse; chk_valid_o |=> !chk_valid_o; endproperty
  a_pulse: assert property (p_pulse) else $error("word pulse too long");
  property p_flag; chk_valid_o |-> chk_corrected_o == (chk_syndrome_o != 3'h0); endproperty
  a_flag: assert property (p_flag) else $error("corrected flag wrong");
  property p_info; chk_valid_o |-> chk_info_o == {chk_word_o[3], chk_word_o[4], chk_word_o[5], chk_word_o[6]}; endproperty
  a_info: assert property (p_info) else $error("info bits wrong");
  property p_clean; chk_valid_o |-> !(^(chk_word_o & 7'h72)) && !(^(chk_word_o & 7'h39)) && !(^(chk_word_o & 7'h5c)); endproperty
  a_clean: assert property (p_clean) else $error("output not a codeword");
  // Counts bits handed over, so the last flag is judged against its position in the word.
  logic [2:0] bits_taken_ff;
  always_ff @(negedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      bits_taken_ff <= 3'h0;
    else if (ser_valid_o && ser_ready_i)
      bits_taken_ff <= ser_last_o ? 3'h0 : bits_taken_ff + 3'h1;
  end
  property p_last; ser_valid_o |-> ser_last_o == (bits_taken_ff == 3'h6); endproperty
  a_last: assert property (p_last) else $error("last flag misplaced");
endmodule
bind hsc_codec hsc_codec_props i_hsc_codec_props (.ref_clk_i, .rst_b_i, .enc_valid_i, .enc_info_i, .enc_ready_o,
  .shift_load_o, .ser_valid_o, .ser_bit_o, .ser_last_o, .ser_ready_i, .rx_valid_i, .rx_bit_i, .chk_valid_o,
  .chk_word_o, .chk_info_o, .chk_syndrome_o, .chk_corrected_o);

// File: hsc_rx_model.sv
// Receiver model: takes serial bits and loops them back, optionally flipped.
// Assumes the codec samples these lines on the falling edge.
`timescale 1ns/10ps
module hsc_rx_model
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic stall_i,
  input wire logic [6:0] flip_i,
  input wire logic ser_valid_i,
  input wire logic ser_bit_i,
  input wire logic ser_last_i,
  output logic ser_ready_o,
  output logic rx_valid_o,
  output logic rx_bit_o
);
  // ****
  // Loopback
  // ****
  logic [2:0] pos;
  always @(negedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ser_ready_o <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_bit_o <= 1'b0;
      pos <= 3'h0;
    end
    else
    begin
      ser_ready_o <= !stall_i;
      rx_valid_o <= ser_valid_i && ser_ready_o;
      rx_bit_o <= (ser_valid_i && ser_ready_o) ? ser_bit_i ^ flip_i[pos] : !rx_bit_o;
      if (ser_valid_i && ser_ready_o)
      begin
        pos <= ser_last_i ? 3'h0 : pos + 3'h1;
      end
    end
  end
endmodule

// File: test_hsc_codec.sv
// Testbench: codec looped through the receiver model.
// Assumes package, codec, checker and model compiled first.
`timescale 1ns/10ps
module test_hsc_codec;
  // ****
  // Parts
  // ****
  logic ref_clk_i, rst_b_i, enc_valid_i, enc_ready_o, shift_load_o, ser_valid_o, ser_bit_o, ser_last_o;
  logic ser_ready_i, rx_valid_i, rx_bit_i, chk_valid_o, chk_corrected_o, stall;
  logic [3:0] enc_info_i, chk_info_o;
  logic [6:0] chk_word_o, flip;
  logic [2:0] chk_syndrome_o;
  hsc_pkg::hsc_cw_t seen [16];
  int mismatches, num_checks;
  hsc_codec i_hsc_codec (.ref_clk_i, .rst_b_i, .enc_valid_i, .enc_info_i, .enc_ready_o, .shift_load_o,
    .ser_valid_o, .ser_bit_o, .ser_last_o, .ser_ready_i, .rx_valid_i, .rx_bit_i, .chk_valid_o, .chk_word_o,
    .chk_info_o, .chk_syndrome_o, .chk_corrected_o);
  hsc_rx_model i_hsc_rx_model (.ref_clk_i, .rst_b_i, .stall_i(stall), .flip_i(flip), .ser_valid_i(ser_valid_o),
    .ser_bit_i(ser_bit_o), .ser_last_i(ser_last_o), .ser_ready_o(ser_ready_i), .rx_valid_o(rx_valid_i),
    .rx_bit_o(rx_bit_i));
  // ****
  // Tasks
  // ****
  function automatic hsc_pkg::hsc_cw_t cw_of(input hsc_pkg::hsc_info_t w);
    return {w[0], w[1], w[2], w[3], w[3] ^ w[2] ^ w[0], w[2] ^ w[1] ^ w[0], w[3] ^ w[2] ^ w[1]};
  endfunction
  task automatic report_and_stop();
    if (mismatches == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmp_word(input hsc_pkg::hsc_cw_t got, input hsc_pkg::hsc_cw_t exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t word %h not %h", $time, got, exp);
    end
  endtask
  task automatic cmp_syn(input hsc_pkg::hsc_syn_t got, input hsc_pkg::hsc_syn_t exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t syndrome %h not %h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t flag %b not %b", $time, got, exp);
    end
  endtask
  task automatic cmp_info(input hsc_pkg::hsc_info_t got, input hsc_pkg::hsc_info_t exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t info %h not %h", $time, got, exp);
    end
  endtask
  // A bounded wait on the ready flag (sel low) or the word strobe (sel high); running out ends the run.
  task automatic wait_for(input logic sel, input logic lvl);
    int n;
    logic cur;
    n = 0;
    cur = ~lvl;
    while (cur !== lvl && n < 300)
    begin
      @(posedge ref_clk_i);
      n++;
      cur = sel ? chk_valid_o : enc_ready_o;
    end
    if (cur !== lvl)
    begin
      mismatches++;
      $display("MISMATCH %0t wait ran out", $time);
      report_and_stop();
    end
  endtask
  task automatic send(input hsc_pkg::hsc_info_t w, input logic [6:0] f, input logic wait_out);
    enc_info_i <= w;
    flip <= f;
    enc_valid_i <= 1'b1;
    wait_for(1'b0, 1'b0);
    enc_valid_i <= 1'b0;
    if (wait_out)
      wait_for(1'b1, 1'b1);
  endtask
  task automatic sc_all_words();
    for (int w = 0; w < 16; w++)
    begin
      send(4'(w), 7'h00, 1'b1);
      cmp_word(chk_word_o, cw_of(4'(w)));
      cmp_syn(chk_syndrome_o, 3'h0);
      cmp_info(chk_info_o, 4'(w));
      seen[w] = chk_word_o;
    end
    for (int i = 0; i < 16; i++)
      for (int j = i + 1; j < 16; j++)
        cmp_flag($countones(seen[i] ^ seen[j]) >= 3, 1'b1);
  endtask
  // Flipping single bits in transit; the syndrome follows from the parity groups.
  task automatic sc_single();
    hsc_pkg::hsc_cw_t f;
    for (int k = 0; k < 7; k++)
    begin
      f = 7'h01 << k;
      send(4'(k + 9), f, 1'b1);
      cmp_word(chk_word_o, cw_of(4'(k + 9)));
      cmp_syn(chk_syndrome_o, {^(f & 7'h72), ^(f & 7'h39), ^(f & 7'h5c)});
      cmp_flag(chk_corrected_o, 1'b1);
      cmp_info(chk_info_o, 4'(k + 9));
    end
  endtask
  // The receiver stalls long enough to fill the buffer and block the encoder.
  task automatic sc_stall();
    stall <= 1'b1;
    send(4'h6, 7'h00, 1'b0);
    repeat (30) @(posedge ref_clk_i);
    cmp_flag(enc_ready_o, 1'b0);
    cmp_flag(ser_valid_o, 1'b1);
    cmp_flag(ser_last_o, 1'b0);
    stall <= 1'b0;
    wait_for(1'b1, 1'b1);
    cmp_word(chk_word_o, cw_of(4'h6));
  endtask
  // ****
  // Run
  // ****
  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  initial
  begin
    rst_b_i = 1'b0;
    enc_valid_i = 1'b0;
    enc_info_i = 4'h0;
    flip = 7'h00;
    stall = 1'b0;
    mismatches = 0;
    num_checks = 0;
    repeat (2) @(posedge ref_clk_i);
    cmp_flag(enc_ready_o, 1'b1);
    cmp_flag(shift_load_o, 1'b0);
    cmp_flag(ser_valid_o, 1'b0);
    rst_b_i <= 1'b1;
    @(posedge ref_clk_i);
    sc_all_words();
    sc_single();
    sc_stall();
    report_and_stop();
  end
endmodule
